// ### hdl/dca_defines.svh
// offsets, field positions and counts of the clear-active / clear-enable banks
`ifndef DCA_DEFINES_SVH
`define DCA_DEFINES_SVH
`define DCA_ENABLE_BASE   16'h0180
`define DCA_ACTIVE_BASE   16'h0380
`define DCA_EXT_BASE      16'h1C00
`define DCA_BANK_SPAN     16'h0080
`define DCA_WORD_BITS     32
`define DCA_BANKED_PES    8
`define DCA_MAX_REGS      32
`define DCA_EXT_ID_BASE   4096
`define DCA_RWP_BIT       31
`define DCA_ACTIVE_RESET  1'b0
`define DCA_ENABLE_RESET  1'b0
`define DCA_PE_SEL_W      3
`define DCA_IDX_LSB       2
`define DCA_IDX_MSB       6
`endif

// ### hdl/dca_pkg.sv
// types shared by the clear-active / clear-enable register block
package dca_pkg;
   typedef enum logic [1:0] {
      DCA_BANK_NONE   = 2'b00,
      DCA_BANK_ENABLE = 2'b01,
      DCA_BANK_ACTIVE = 2'b10,
      DCA_BANK_EXT    = 2'b11
   } dca_bank_t;
endpackage : dca_pkg

// ### hdl/dist_clear_active_enable.sv
// clear-active, extended clear-active and clear-enable register banks of the distributor
//
// Function
// - read shows active or active-and-pending
// - write one deactivates an active interrupt
// - write zero changes nothing
// - all active bits zero after reset
// - active bank at 0x380, word m/32
// - line group count plus one registers
// - word zero banked per element below eight
// - affinity routing hides private active bits
// - unimplemented interrupts read zero, ignore writes
// - nonsecure hidden from secure groups unless granted
// - extended bank exists only when present
// - extended bank at 0x1C00, id minus 4096
// - extended bits need affinity, hide secure ones
// - enable reads set, write one disables
// - enable reset value left open
// - enable bank at 0x180, word m/32
// - disable stops forwarding only, not state
// - affinity routing hides private enable bits
// - nonsecure hidden from secure-group enables
// - software interrupts disabled through word zero
// - write-pending held until disable propagates
// - write-pending set while shared disables propagate
`include "dca_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module dist_clear_active_enable #(
   parameter  int LINE_GROUP_COUNT = 1,
   parameter  int EXT_PRESENT      = 1,
   parameter  int EXT_RANGE_SIZE   = 0,
   parameter  int PE_W             = 4,
   parameter  int PROP_CYCLES      = 8,
   localparam int W                = `DCA_WORD_BITS,
   localparam int N                = (LINE_GROUP_COUNT + 1) * W,
   localparam int SN               = N - W,
   localparam int NE               = (EXT_RANGE_SIZE + 1) * W,
   localparam int NP               = `DCA_BANKED_PES,
   localparam int CW               = $clog2(PROP_CYCLES + 1)
) (
   input  wire logic                 clk,
   input  wire logic                 rst,
   input  wire logic                 ce,
   input  wire logic                 req,
   input  wire logic                 reqWrite,
   input  wire logic [15:0]          reqAddr,
   input  wire logic [W-1:0]         reqWdata,
   input  wire logic                 reqNonSecure,
   input  wire logic [PE_W-1:0]      reqPe,
   input  wire logic                 securityDisable,
   input  wire logic                 affinitySecure,
   input  wire logic                 affinityNonSecure,
   input  wire logic [N-1:0]         groupSecure,
   input  wire logic [N-1:0]         nsGrant,
   input  wire logic [N-1:0]         implemented,
   input  wire logic [NE-1:0]        extSecure,
   input  wire logic [NE-1:0]        extImplemented,
   input  wire logic [N-1:0]         setActive,
   input  wire logic [N-1:0]         setEnable,
   input  wire logic [2:0]           setPe,
   input  wire logic [NE-1:0]        setExtActive,
   output logic                      ack,
   output logic [W-1:0]              rdata,
   output logic                      writePending,
   output logic [NP*W-1:0]           privActiveState,
   output logic [NP*W-1:0]           privEnableState,
   output logic [SN-1:0]             sharedActiveState,
   output logic [SN-1:0]             sharedEnableState,
   output logic [NE-1:0]             extActiveState
);

   // parameter values the logic cannot serve stop elaboration
   if (LINE_GROUP_COUNT < 1 || LINE_GROUP_COUNT >= `DCA_MAX_REGS) begin : g_bad_lines
      $error("LINE_GROUP_COUNT out of range");
   end
   if (EXT_RANGE_SIZE < 0 || EXT_RANGE_SIZE >= `DCA_MAX_REGS) begin : g_bad_ext
      $error("EXT_RANGE_SIZE out of range");
   end
   if (PE_W < `DCA_PE_SEL_W || PE_W > `DCA_WORD_BITS || PROP_CYCLES < 1) begin : g_bad_misc
      $error("PE_W or PROP_CYCLES out of range");
   end

   typedef struct packed {
      logic [NP-1:0][W-1:0] privActive;
      logic [NP-1:0][W-1:0] privEnable;
      logic [SN-1:0]        sharedActive;
      logic [SN-1:0]        sharedEnable;
      logic [NE-1:0]        extActive;
      logic [CW-1:0]        propCount;
      logic                 writePending;
      logic                 ack;
      logic [W-1:0]         rdata;
   } dca_state_t;

   dca_state_t            state;
   dca_state_t            next_state;
   dca_pkg::dca_bank_t    reqKind;
   logic [4:0]            reqIdx;
   logic                  reqValid;
   logic [W-1:0]          curWord;
   logic [W-1:0]          secWord;
   logic [W-1:0]          grantWord;
   logic [W-1:0]          implWord;
   logic [W-1:0]          accMask;
   logic [W-1:0]          clrWord;
   logic                  enStart;

   localparam logic [CW-1:0] PROP_LOAD = CW'(PROP_CYCLES);

   // bank selected by a word-aligned byte address
   function automatic dca_pkg::dca_bank_t bankOf(input logic [15:0] a);
      if (a[1:0] != 2'h0)
         return dca_pkg::DCA_BANK_NONE;
      if (a >= `DCA_ENABLE_BASE && a < `DCA_ENABLE_BASE + `DCA_BANK_SPAN)
         return dca_pkg::DCA_BANK_ENABLE;
      if (a >= `DCA_ACTIVE_BASE && a < `DCA_ACTIVE_BASE + `DCA_BANK_SPAN)
         return dca_pkg::DCA_BANK_ACTIVE;
      if (a >= `DCA_EXT_BASE && a < `DCA_EXT_BASE + `DCA_BANK_SPAN)
         return dca_pkg::DCA_BANK_EXT;
      return dca_pkg::DCA_BANK_NONE;
   endfunction : bankOf

   // bits of one word the current access may see and change
   function automatic logic [W-1:0] permit(input dca_pkg::dca_bank_t kind, input logic priv,
                                           input logic [W-1:0] sec, input logic [W-1:0] grant);
      logic [W-1:0] m;
      logic         are;
      m = '1;
      for (int b = 0; b < W; b++) begin
         are = securityDisable ? affinitySecure : (sec[b] ? affinitySecure : affinityNonSecure);
         if (priv && are)
            m[b] = 1'b0;
         if (kind == dca_pkg::DCA_BANK_EXT && !are)
            m[b] = 1'b0;
         if (reqNonSecure && !securityDisable && sec[b]) begin
            if (kind != dca_pkg::DCA_BANK_ACTIVE || !grant[b])
               m[b] = 1'b0;
         end
      end
      return m;
   endfunction : permit

   always_comb begin
      int base;
      logic [`DCA_PE_SEL_W-1:0] pe;
      next_state = state;
      next_state.ack = 1'b0;
      base = 0;
      pe = reqPe[`DCA_PE_SEL_W-1:0];
      reqKind = bankOf(reqAddr);
      reqIdx = reqAddr[`DCA_IDX_MSB:`DCA_IDX_LSB];
      reqValid = 1'b0;
      curWord = '0;
      secWord = '0;
      grantWord = '0;
      implWord = '0;
      enStart = 1'b0;
      case (reqKind)
         dca_pkg::DCA_BANK_ENABLE,
         dca_pkg::DCA_BANK_ACTIVE: begin
            reqValid = 32'(reqIdx) <= LINE_GROUP_COUNT;
            if (reqValid) begin
               base = 32'(reqIdx) * W;
               secWord = groupSecure[base +: W];
               grantWord = nsGrant[base +: W];
               implWord = implemented[base +: W];
               if (reqIdx == 5'h0) begin
                  if (reqKind == dca_pkg::DCA_BANK_ACTIVE)
                     curWord = state.privActive[pe];
                  else
                     curWord = state.privEnable[pe];
                  // high element numbers leave every bank copy untouched
                  if (32'(reqPe) >= NP)
                     implWord = '0;
               end else if (reqKind == dca_pkg::DCA_BANK_ACTIVE) begin
                  curWord = state.sharedActive[base - W +: W];
               end else begin
                  curWord = state.sharedEnable[base - W +: W];
               end
            end
         end
         dca_pkg::DCA_BANK_EXT: begin
            reqValid = EXT_PRESENT != 0 && 32'(reqIdx) <= EXT_RANGE_SIZE;
            if (reqValid) begin
               base = 32'(reqIdx) * W;
               secWord = extSecure[base +: W];
               implWord = extImplemented[base +: W];
               curWord = state.extActive[base +: W];
            end
         end
         default: begin
            reqValid = 1'b0;
         end
      endcase
      accMask = permit(reqKind, reqIdx == 5'h0 && reqKind != dca_pkg::DCA_BANK_EXT, secWord, grantWord)
                & implWord;
      clrWord = (req && reqWrite && reqValid) ? (reqWdata & accMask) : '0;

      if (req) begin
         next_state.ack = 1'b1;
         if (!reqWrite)
            next_state.rdata = curWord & accMask;
      end
      if (req && reqWrite && reqValid) begin
         case (reqKind)
            dca_pkg::DCA_BANK_ACTIVE: begin
               if (reqIdx == 5'h0)
                  next_state.privActive[pe] = curWord & ~clrWord;
               else
                  next_state.sharedActive[base - W +: W] = curWord & ~clrWord;
            end
            dca_pkg::DCA_BANK_ENABLE: begin
               if (reqIdx == 5'h0)
                  next_state.privEnable[pe] = curWord & ~clrWord;
               else begin
                  next_state.sharedEnable[base - W +: W] = curWord & ~clrWord;
                  enStart = |(clrWord & curWord);
               end
            end
            dca_pkg::DCA_BANK_EXT: begin
               next_state.extActive[base +: W] = curWord & ~clrWord;
            end
            default: begin
               next_state.rdata = state.rdata;
            end
         endcase
      end

      // propagation window of a shared disable
      if (enStart)
         next_state.propCount = PROP_LOAD;
      else if (state.propCount != '0)
         next_state.propCount = state.propCount - CW'(1);
      next_state.writePending = next_state.propCount != '0;

      // new activations and enables from the distributor win over a clear
      for (int b = 0; b < W; b++) begin
         if (setActive[b] && implemented[b])
            next_state.privActive[setPe][b] = 1'b1;
         if (setEnable[b] && implemented[b])
            next_state.privEnable[setPe][b] = 1'b1;
      end
      for (int b = 0; b < SN; b++) begin
         if (setActive[b + W] && implemented[b + W])
            next_state.sharedActive[b] = 1'b1;
         if (setEnable[b + W] && implemented[b + W])
            next_state.sharedEnable[b] = 1'b1;
      end
      for (int b = 0; b < NE; b++) begin
         if (EXT_PRESENT != 0 && setExtActive[b] && extImplemented[b])
            next_state.extActive[b] = 1'b1;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state <= '0;
      end else if (ce) begin
         state <= next_state;
      end
   end

   assign ack               = state.ack;
   assign rdata             = state.rdata;
   assign writePending      = state.writePending;
   assign privActiveState   = state.privActive;
   assign privEnableState   = state.privEnable;
   assign sharedActiveState = state.sharedActive;
   assign sharedEnableState = state.sharedEnable;
   assign extActiveState    = state.extActive;

   // helper: first enabled cycle after reset
   logic firstCycle;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         firstCycle <= 1'b1;
      end else if (ce) begin
         firstCycle <= 1'b0;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   sequence readReq;
      ce && req && !reqWrite;
   endsequence
   sequence writeReq;
      ce && req && reqWrite;
   endsequence
   sequence zeroWrite;
      writeReq ##0 (reqWdata == '0 && setActive == '0 && setEnable == '0 && setExtActive == '0);
   endsequence
   sequence highPeRead;
      readReq ##0 (reqIdx == 5'h0 && 32'(reqPe) >= NP && reqKind != dca_pkg::DCA_BANK_EXT);
   endsequence
   sequence highPeWrite;
      writeReq ##0 (reqIdx == 5'h0 && 32'(reqPe) >= NP && reqKind != dca_pkg::DCA_BANK_EXT
                    && setActive == '0 && setEnable == '0);
   endsequence
   sequence privRoutedRead;
      readReq ##0 (reqIdx == 5'h0 && affinitySecure && affinityNonSecure);
   endsequence
   sequence outOfRangeRead;
      readReq ##0 ((reqKind == dca_pkg::DCA_BANK_ACTIVE || reqKind == dca_pkg::DCA_BANK_ENABLE)
                   && 32'(reqIdx) > LINE_GROUP_COUNT);
   endsequence
   sequence extOutsideRead;
      readReq ##0 (reqKind == dca_pkg::DCA_BANK_EXT && (EXT_PRESENT == 0 || 32'(reqIdx) > EXT_RANGE_SIZE));
   endsequence

   bus_ack_a: assert property (ce && req |=> ack) else $error("no ack after request");
   read_data_a: assert property (readReq |=> rdata == ($past(curWord) & $past(accMask)))
      else $error("read data mismatch");
   zero_write_a: assert property (zeroWrite |=> $stable(state.sharedActive) && $stable(state.privActive)
                                  && $stable(state.sharedEnable))
      else $error("zero write changed state");
   reset_clear_a: assert property (firstCycle |-> state.sharedActive == '0 && state.privActive == '0
                                   && state.extActive == '0)
      else $error("active bits not zero after reset");
   banked_pe_a: assert property (highPeRead |=> rdata == '0)
      else $error("high element number not read as zero");
   banked_write_a: assert property (highPeWrite |=> $stable(state.privActive) && $stable(state.privEnable))
      else $error("high element number write changed a bank");
   priv_route_a: assert property (privRoutedRead ##0 (reqKind == dca_pkg::DCA_BANK_ACTIVE) |=> rdata == '0)
      else $error("private bits visible under affinity routing");
   priv_enable_a: assert property (privRoutedRead ##0 (reqKind == dca_pkg::DCA_BANK_ENABLE) |=> rdata == '0)
      else $error("private enables visible under affinity routing");
   range_read_a: assert property (outOfRangeRead |=> rdata == '0)
      else $error("register beyond line group count not zero");
   unimpl_bits_a: assert property (ce && req |-> (accMask & ~implWord) == '0)
      else $error("unimplemented bit accessible");
   ns_secure_a: assert property (ce && req && reqNonSecure && !securityDisable
                                 && reqKind == dca_pkg::DCA_BANK_ENABLE |-> (accMask & secWord) == '0)
      else $error("secure enable visible to nonsecure access");
   ext_route_a: assert property (readReq ##0 (reqKind == dca_pkg::DCA_BANK_EXT && !affinitySecure
                                  && !affinityNonSecure) |=> rdata == '0)
      else $error("extended bits visible without affinity routing");
   ext_outside_a: assert property (extOutsideRead |=> rdata == '0)
      else $error("missing extended register not zero");
   pend_start_a: assert property (ce && enStart |=> writePending && state.propCount == PROP_LOAD)
      else $error("write pending not raised");
   pend_hold_a: assert property ($fell(writePending) |-> $past(state.propCount) == CW'(1))
      else $error("write pending dropped early");
   ext_absent_a: assert property (EXT_PRESENT == 0 |-> state.extActive == '0)
      else $error("extended bits present without feature");

endmodule : dist_clear_active_enable
`default_nettype wire

// ### bench/dca_sw_host.sv
// software-side master model issuing register accesses and polling write-pending
`timescale 1ns/1ps
`default_nettype none
module dca_sw_host #(
   parameter int PE_W = 4
) (
   input  wire logic            clk,
   input  wire logic            ack,
   input  wire logic [31:0]     rdata,
   input  wire logic            writePending,
   output logic                 req,
   output logic                 reqWrite,
   output logic [15:0]          reqAddr,
   output logic [31:0]          reqWdata,
   output logic                 reqNonSecure,
   output logic [PE_W-1:0]      reqPe
);
   initial begin
      req = 1'b0;
      reqWrite = 1'b0;
      reqAddr = 16'h5A5A;
      reqWdata = 32'hA5A5_A5A5;
      reqNonSecure = 1'b0;
      reqPe = '0;
   end
   // one pulse per access; write, address and data lines scrambled once the request is taken
   task automatic access(input logic wr, input logic ns, input logic [PE_W-1:0] pe, input logic [15:0] addr,
                         input logic [31:0] wdata, output logic [31:0] rd, output logic gotAck);
      @(posedge clk);
      #1;
      req = 1'b1;
      reqWrite = wr;
      reqNonSecure = ns;
      reqPe = pe;
      reqAddr = addr;
      reqWdata = wdata;
      @(posedge clk);
      #1;
      gotAck = ack;
      rd = rdata;
      req = 1'b0;
      reqWrite = ~wr;
      reqAddr = ~addr;
      reqWdata = ~wdata;
   endtask : access
   // wait until disables have propagated
   task automatic poll_pending(input int limit, output int waited);
      waited = 0;
      while (writePending === 1'b1 && waited < limit) begin
         @(posedge clk);
         #1;
         waited++;
      end
   endtask : poll_pending
endmodule : dca_sw_host
`default_nettype wire

// ### bench/tb.sv
// self-checking bench for the clear-active / clear-enable register banks
`timescale 1ns/1ps
`default_nettype none
`define DCA_CHECK(got, exp) begin checked++; if ((got) !== (exp)) begin errors++; \
   $display("wrong value at %0t: got %h expected %h", $time, got, exp); end end
module tb;
   localparam int PC = 3;
   localparam int N  = 64;
   localparam int NE = 32;
   typedef struct packed {
      logic [2:0]  cfg;
      logic        wr;
      logic        ns;
      logic [3:0]  pe;
      logic [15:0] addr;
      logic [31:0] data;
   } dca_row_t;
   logic             clk = 1'b0;
   logic             rst = 1'b1;
   logic             ce = 1'b1;
   logic             securityDisable = 1'b0;
   logic             affinitySecure = 1'b0;
   logic             affinityNonSecure = 1'b0;
   logic [N-1:0]     groupSecure = {32'h0000_FF00, 32'h0};
   logic [N-1:0]     nsGrant = {32'h0000_3000, 32'h0};
   logic [N-1:0]     implemented = {32'h0FFF_FFFF, 32'hFFFF_FFFF};
   logic [NE-1:0]    extSecure = 32'h0000_000F;
   logic [NE-1:0]    extImplemented = '1;
   logic [N-1:0]     setActive = '0;
   logic [N-1:0]     setEnable = '0;
   logic [2:0]       setPe = 3'h0;
   logic [NE-1:0]    setExtActive = '0;
   wire logic        req, reqWrite, reqNonSecure, ack, writePending;
   wire logic [15:0] reqAddr;
   wire logic [31:0] reqWdata, rdata;
   wire logic [3:0]  reqPe;
   wire logic [255:0] privActiveState, privEnableState;
   wire logic [31:0] sharedActiveState, sharedEnableState, extActiveState;
   logic [31:0]      rd;
   logic             got;
   int               waited;
   int               errors = 0;
   int               checked = 0;
   int               cycles = 0;
   dca_row_t rows [27] = '{
      {3'h0, 2'b00, 4'h0, 16'h0380, 32'hFFFF_FFFF}, {3'h0, 2'b00, 4'h1, 16'h0380, 32'h0000_00FF},
      {3'h0, 2'b00, 4'h8, 16'h0380, 32'h0}, {3'h0, 2'b00, 4'h0, 16'h0384, 32'h0FFF_FFFF},
      {3'h0, 2'b01, 4'h0, 16'h0384, 32'h0FFF_30FF}, {3'h0, 2'b01, 4'h0, 16'h0184, 32'h0FFF_00FF},
      {3'h0, 2'b00, 4'h0, 16'h0388, 32'h0}, {3'h0, 2'b00, 4'h0, 16'h0188, 32'h0},
      {3'h0, 2'b00, 4'h0, 16'h1C00, 32'h0}, {3'h4, 2'b01, 4'h0, 16'h0184, 32'h0FFF_FFFF},
      {3'h0, 2'b11, 4'h0, 16'h0384, 32'hFFFF_FFFF}, {3'h0, 2'b00, 4'h0, 16'h0384, 32'h0000_CF00},
      {3'h0, 2'b10, 4'h0, 16'h0384, 32'h0000_0100}, {3'h0, 2'b00, 4'h0, 16'h0384, 32'h0000_CE00},
      {3'h0, 2'b10, 4'h0, 16'h0180, 32'h0000_0001}, {3'h0, 2'b00, 4'h0, 16'h0180, 32'hFFFF_FFFE},
      {3'h3, 2'b00, 4'h0, 16'h0380, 32'h0}, {3'h3, 2'b00, 4'h0, 16'h0180, 32'h0},
      {3'h3, 2'b00, 4'h0, 16'h1C00, 32'hFFFF_FFFF}, {3'h3, 2'b01, 4'h0, 16'h1C00, 32'hFFFF_FFF0},
      {3'h3, 2'b11, 4'h0, 16'h1C00, 32'hFFFF_FFFF}, {3'h3, 2'b00, 4'h0, 16'h1C00, 32'h0000_000F},
      {3'h3, 2'b00, 4'h0, 16'h1C04, 32'h0}, {3'h0, 2'b10, 4'h8, 16'h0380, 32'hFFFF_FFFF},
      {3'h0, 2'b00, 4'h0, 16'h0380, 32'hFFFF_FFFF}, {3'h0, 2'b10, 4'h0, 16'h0384, 32'h0},
      {3'h0, 2'b00, 4'h0, 16'h0384, 32'h0000_CE00}};

   always #2 clk = ~clk;

   dist_clear_active_enable #(.LINE_GROUP_COUNT(1), .EXT_PRESENT(1), .EXT_RANGE_SIZE(0), .PE_W(4),
                              .PROP_CYCLES(PC)) i_dut (
      .clk(clk), .rst(rst), .ce(ce), .req(req), .reqWrite(reqWrite), .reqAddr(reqAddr), .reqWdata(reqWdata),
      .reqNonSecure(reqNonSecure), .reqPe(reqPe), .securityDisable(securityDisable),
      .affinitySecure(affinitySecure), .affinityNonSecure(affinityNonSecure), .groupSecure(groupSecure),
      .nsGrant(nsGrant), .implemented(implemented), .extSecure(extSecure), .extImplemented(extImplemented),
      .setActive(setActive), .setEnable(setEnable), .setPe(setPe), .setExtActive(setExtActive), .ack(ack),
      .rdata(rdata), .writePending(writePending), .privActiveState(privActiveState),
      .privEnableState(privEnableState), .sharedActiveState(sharedActiveState),
      .sharedEnableState(sharedEnableState), .extActiveState(extActiveState));

   dca_sw_host #(.PE_W(4)) i_host (
      .clk(clk), .ack(ack), .rdata(rdata), .writePending(writePending), .req(req), .reqWrite(reqWrite),
      .reqAddr(reqAddr), .reqWdata(reqWdata), .reqNonSecure(reqNonSecure), .reqPe(reqPe));

   task automatic final_report();
      $display("comparisons %0d mismatches %0d", checked, errors);
      if (errors == 0 && checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : final_report

   task automatic pulse(input logic [N-1:0] act, input logic [N-1:0] en, input logic [2:0] pe,
                        input logic [NE-1:0] ext);
      @(posedge clk);
      #1;
      {setActive, setEnable, setPe, setExtActive} = {act, en, pe, ext};
      @(posedge clk);
      #1;
      {setActive, setEnable, setExtActive} = '0;
   endtask : pulse

   always @(posedge clk) begin
      cycles++;
      if (cycles == 4000) begin
         errors++;
         final_report();
      end
   end

   initial begin
      repeat (8) @(posedge clk);
      #1 rst = 1'b0;
      `DCA_CHECK({ack, rdata, writePending, privActiveState, privEnableState, sharedActiveState}, '0)
      `DCA_CHECK({sharedEnableState, extActiveState}, '0)
      pulse('1, '1, 3'h0, '1);
      pulse({32'h0, 32'h0000_00FF}, '0, 3'h1, '0);
      for (int i = 0; i < 27; i++) begin
         {securityDisable, affinitySecure, affinityNonSecure} = rows[i].cfg;
         i_host.access(rows[i].wr, rows[i].ns, rows[i].pe, rows[i].addr, rows[i].data, rd, got);
         `DCA_CHECK(got, 1'b1)
         if (!rows[i].wr) `DCA_CHECK(rd, rows[i].data)
      end
      {securityDisable, affinitySecure, affinityNonSecure} = 3'h0;
      i_host.access(1'b1, 1'b0, 4'h0, 16'h0184, 32'h0000_0001, rd, got);
      `DCA_CHECK({writePending, sharedEnableState[0], sharedActiveState[9]}, 3'b101)
      i_host.poll_pending(20, waited);
      `DCA_CHECK(waited, PC)
      pulse({32'h0000_0001, 32'h0}, '0, 3'h0, '0);
      `DCA_CHECK({sharedActiveState[0], sharedEnableState[0]}, 2'b10)
      i_host.access(1'b1, 1'b0, 4'h0, 16'h0184, 32'h0000_0001, rd, got);
      `DCA_CHECK(writePending, 1'b0)
      // let the last ack drop before freezing
      @(posedge clk);
      #1;
      ce = 1'b0;
      i_host.access(1'b0, 1'b0, 4'h0, 16'h0380, 32'h0, rd, got);
      `DCA_CHECK(got, 1'b0)
      ce = 1'b1;
      rst = 1'b1;
      @(posedge clk);
      #1;
      `DCA_CHECK({privActiveState, sharedActiveState, extActiveState, writePending}, '0)
      rst = 1'b0;
      i_host.access(1'b0, 1'b0, 4'h0, 16'h0384, 32'h0, rd, got);
      `DCA_CHECK(rd, 32'h0)
      final_report();
   end
endmodule : tb
`default_nettype wire
